/* common/rsie_pkg.sv */
// Package for the stack instruction executor: opcodes, number layout, timing.
// Assumes a 25 MHz single clock and an external arithmetic unit.
package rsie_pkg;

  // ----------------------------------------
  // Number format and carriers
  // ----------------------------------------
  typedef struct packed {
    logic        ms;   // Mantissa sign
    logic [31:0] man;  // Eight BCD digits, most significant first
    logic        es;   // Exponent sign
    logic [7:0]  ex;   // Two BCD digits
  } rsie_num_s;

  typedef struct packed {
    logic [6:0] op;    // {prefix, opcode}
    rsie_num_s  a;     // X operand
    rsie_num_s  b;     // Y or memory operand
  } rsie_mreq_s;

  localparam rsie_num_s NUM_ZERO = '{ms: 1'b0, man: 32'h0, es: 1'b0, ex: 8'h0};
  localparam rsie_num_s PI_CONST = '{ms: 1'b0, man: 32'h31415927, es: 1'b0, ex: 8'h0};

  // ----------------------------------------
  // Opcodes (octal)
  // ----------------------------------------
  localparam logic [5:0] OP_DIGIT9    = 6'o11;
  localparam logic [5:0] OP_DP        = 6'o12;
  localparam logic [5:0] OP_EE        = 6'o13;
  localparam logic [5:0] OP_CS        = 6'o14;
  localparam logic [5:0] OP_PI        = 6'o15;
  localparam logic [5:0] OP_HALT      = 6'o17;
  localparam logic [5:0] OP_BR_COND   = 6'o20;
  localparam logic [5:0] OP_BR_XZERO  = 6'o21;
  localparam logic [5:0] OP_BR_ERR    = 6'o24;
  localparam logic [5:0] OP_BR_ALWAYS = 6'o25;
  localparam logic [5:0] OP_XSWAPM    = 6'o33;
  localparam logic [5:0] OP_MSTORE    = 6'o34;
  localparam logic [5:0] OP_MRECALL   = 6'o35;
  localparam logic [5:0] OP_SHUP      = 6'o36;
  localparam logic [5:0] OP_SHDN      = 6'o37;
  localparam logic [5:0] OP_PREFIX    = 6'o40;
  localparam logic [5:0] OP_ENTER     = 6'o41;
  localparam logic [5:0] OP_ROLL      = 6'o43;
  localparam logic [5:0] OP_SIN       = 6'o44;
  localparam logic [5:0] OP_TAN       = 6'o46;
  localparam logic [5:0] OP_ECLR      = 6'o53;
  localparam logic [5:0] OP_RTD       = 6'o54;
  localparam logic [5:0] OP_DTR       = 6'o55;
  localparam logic [5:0] OP_POP       = 6'o56;
  localparam logic [5:0] OP_FULLCLR   = 6'o57;
  localparam logic [5:0] OP_XSWAPY    = 6'o60;
  localparam logic [5:0] OP_EXPE      = 6'o61;
  localparam logic [5:0] OP_RECIP     = 6'o67;
  localparam logic [5:0] OP_POWER     = 6'o70;
  localparam logic [5:0] OP_ADD       = 6'o71;
  localparam logic [5:0] OP_DIVIDE    = 6'o74;
  localparam logic [5:0] OP_IDLE      = 6'o77;
  localparam logic [6:0] OP_NORMALIZE = 7'h7f;

  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [3:0]  MDC_INIT     = 4'h8;
  localparam int          CLK_NS       = 40;
  localparam int          ACCESS_NS    = 80000;
  localparam logic [10:0] ACCESS_CYC   = 11'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] HALT_DRV_CYC = 11'h4;

  typedef enum logic [1:0] {D_NORM, D_XPOP, D_X, D_M} rsie_dst_e;

endpackage

/* core/rsie_exec.sv */
// Instruction fetch, decode and execute for the stack number processor.
// Assumes an instruction store on the ready/hold handshake and an external
// arithmetic unit that answers each request with one done pulse.
//
// Function
// - Octal 15 loads circle constant, no push
// - Enter ends entry, pushes, X kept in Y
// - Idle op changes nothing, ends entry
// - Halt drives hold high, waits hold low
// - Drop: Y to X, Z to Y, T to Z, T cleared
// - Octal 33 swaps X and memory
// - Octal 35 pushes, memory into X
// - Octal 36 shifts mantissa up via link
// - Octal 37 shifts mantissa down from link
// - Two-operand result to X, stack popped
// - Octal 71 adds X and Y, then pops
// - Prefix plus arithmetic other than power combines X into memory
// - One-operand math replaces X only
// - Trig and inverses replace X only
// - Change sign hits exponent after exponent entry
// - Full clear zeroes all, digit count 8
// - Branch always loads second word into counter
// - Condition pin high branches, else skip
// - Octal 24 branches when error set
// - Octal 21 branches when X zero
// - Only six opcode bits are decoded
// - Other instructions end entry and normalize
module rsie_exec
  import rsie_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Instruction store
  input  wire logic [7:0] instr_word,
  output logic            rdy,
  input  wire logic       hold_i,
  output logic            hold_o,
  output logic            hold_oe,
  output logic            pc_load,
  output logic [7:0]      pc_target,
  input  wire logic       branch_condition_pin,
  // Arithmetic unit
  output logic            math_req,
  output rsie_mreq_s      math_cmd,
  input  wire logic       math_done,
  input  wire rsie_num_s  math_result,
  input  wire logic       math_error,
  // Status
  output rsie_num_s       x_value,
  output logic            error_flag,
  output logic            entry_active,
  output logic [3:0]      digit_count,
  output logic            sci_mode
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] hsync_reg, hsync_next, csync_reg, csync_next;
  logic       hold_s_reg, hold_s_next, cond_s_reg, cond_s_next;

  always_comb begin
    hsync_next  = {hsync_reg[1:0], hold_i};
    csync_next  = {csync_reg[1:0], branch_condition_pin};
    // Only agreeing later stages count, so a one-cycle glitch never registers
    hold_s_next = (hsync_reg[1] == hsync_reg[2]) ? hsync_reg[2] : hold_s_reg;
    cond_s_next = (csync_reg[1] == csync_reg[2]) ? csync_reg[2] : cond_s_reg;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hsync_reg  <= 3'h0;
      csync_reg  <= 3'h0;
      hold_s_reg <= 1'b0;
      cond_s_reg <= 1'b0;
    end else begin
      hsync_reg  <= hsync_next;
      csync_reg  <= csync_next;
      hold_s_reg <= hold_s_next;
      cond_s_reg <= cond_s_next;
    end
  end

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  typedef enum logic [6:0] {
    S_FETCH  = 7'h01, S_EXEC  = 7'h02, S_MATH  = 7'h04, S_FETCH2 = 7'h08,
    S_HALT   = 7'h10, S_HWAIT = 7'h20, S_IDLE0 = 7'h40
  } rsie_state_e;

  rsie_state_e state_reg, state_next;
  rsie_num_s   x_reg, x_next, y_reg, y_next, z_reg, z_next;
  rsie_num_s   t_reg, t_next, m_reg, m_next;
  rsie_dst_e   dst_reg, dst_next;
  rsie_mreq_s  cmd_reg, cmd_next;
  logic [5:0]  op_reg, op_next;
  logic [10:0] wait_reg, wait_next;
  logic [3:0]  link_reg, link_next, cnt_reg, cnt_next, mdc_reg, mdc_next;
  logic [7:0]  pca_reg, pca_next;
  logic        entry_reg, entry_next, exp_reg, exp_next, enter_reg, enter_next;
  logic        pre_reg, pre_next, err_reg, err_next, sci_reg, sci_next;
  logic        req_reg, req_next, pcl_reg, pcl_next, take;

  // Entry survives only digits, point, exponent, sign, constant and halt
  function automatic logic ends_entry(input logic [5:0] op);
    return !(op <= OP_PI || op == OP_HALT);
  endfunction

  function automatic logic is_unary(input logic [5:0] op);
    return (op >= OP_SIN && op <= OP_TAN) || op == OP_RTD || op == OP_DTR
        || (op >= OP_EXPE && op <= OP_RECIP);
  endfunction

  assign take = (state_reg == S_FETCH || state_reg == S_FETCH2)
             && wait_reg == ACCESS_CYC && !hold_s_reg;

  always_comb begin
    state_next = state_reg;  x_next = x_reg;  y_next = y_reg;  z_next = z_reg;
    t_next = t_reg;  m_next = m_reg;  dst_next = dst_reg;  cmd_next = cmd_reg;
    op_next = op_reg;  wait_next = wait_reg;  link_next = link_reg;
    cnt_next = cnt_reg;  mdc_next = mdc_reg;  pca_next = pca_reg;
    entry_next = entry_reg;  exp_next = exp_reg;  enter_next = enter_reg;
    pre_next = pre_reg;  err_next = err_reg;  sci_next = sci_reg;
    req_next = 1'b0;  pcl_next = 1'b0;
    unique case (state_reg)
      S_FETCH, S_FETCH2: begin
        if (wait_reg != ACCESS_CYC) begin
          wait_next = wait_reg + 11'h1;
        end else if (take) begin
          wait_next = 11'h0;
          state_next = S_FETCH;
          if (state_reg == S_FETCH2) begin
            // Rdy drops one cycle so the store steps past a skipped word
            state_next = S_HWAIT;
            // Branch target comes whole from the second word
            unique case (op_reg)
              OP_BR_ALWAYS: pcl_next = 1'b1;
              OP_BR_COND:   pcl_next = cond_s_reg;
              OP_BR_ERR:    pcl_next = err_reg;
              default:      pcl_next = (x_reg.man == 32'h0);
            endcase
            pca_next = instr_word;
          end else begin
            op_next = instr_word[5:0];
            if (entry_reg && ends_entry(instr_word[5:0])) begin
              // Normalize before the ending instruction runs
              entry_next = 1'b0;
              req_next = 1'b1;
              cmd_next = '{op: OP_NORMALIZE, a: x_reg, b: y_reg};
              dst_next = D_NORM;
              state_next = S_MATH;
            end else begin
              state_next = S_EXEC;
            end
          end
        end
      end
      S_MATH: begin
        if (math_done) begin
          err_next = err_reg | math_error;
          state_next = S_FETCH;
          unique case (dst_reg)
            D_NORM: begin
              x_next = math_result;
              state_next = S_EXEC;
            end
            D_XPOP: begin
              x_next = math_result;
              y_next = z_reg;
              z_next = t_reg;
              t_next = NUM_ZERO;
            end
            D_X: x_next = math_result;
            D_M: m_next = math_result;
          endcase
        end
      end
      S_EXEC: begin
        state_next = S_FETCH;
        enter_next = (op_reg == OP_ENTER);
        pre_next = (op_reg == OP_PREFIX);
        if (ends_entry(op_reg)) begin
          entry_next = 1'b0;
          exp_next = 1'b0;
        end
        if (op_reg <= OP_DP) begin
          if (!entry_reg) begin
            // Initiation: push unless just entered, then clear X
            if (!enter_reg) begin
              t_next = z_reg;
              z_next = y_reg;
              y_next = x_reg;
            end
            x_next = NUM_ZERO;
            x_next.man[3:0] = (op_reg == OP_DP) ? 4'h0 : op_reg[3:0];
            cnt_next = 4'h1;
            entry_next = 1'b1;
            exp_next = 1'b0;
          end else if (op_reg != OP_DP && exp_reg) begin
            x_next.ex = {x_reg.ex[3:0], op_reg[3:0]};
          end else if (op_reg != OP_DP && cnt_reg < MDC_INIT) begin
            // Digits past the eighth are dropped
            x_next.man = {x_reg.man[27:0], op_reg[3:0]};
            cnt_next = cnt_reg + 4'h1;
          end
        end
        unique case (op_reg)
          OP_EE: exp_next = 1'b1;
          OP_CS: begin
            if (exp_reg) x_next.es = !x_reg.es;
            else x_next.ms = !x_reg.ms;
          end
          OP_PI: x_next = PI_CONST;
          OP_HALT: begin
            wait_next = 11'h0;
            state_next = S_HALT;
          end
          OP_ENTER, OP_MRECALL: begin
            t_next = z_reg;
            z_next = y_reg;
            y_next = x_reg;
            if (op_reg == OP_MRECALL) x_next = m_reg;
          end
          OP_ROLL: begin
            // Direction assumed downward, X wraps into T
            x_next = y_reg;
            y_next = z_reg;
            z_next = t_reg;
            t_next = x_reg;
          end
          OP_POP: begin
            x_next = y_reg;
            y_next = z_reg;
            z_next = t_reg;
            t_next = NUM_ZERO;
          end
          OP_XSWAPY: begin
            x_next = y_reg;
            y_next = x_reg;
          end
          OP_XSWAPM: begin
            x_next = m_reg;
            m_next = x_reg;
          end
          OP_MSTORE: m_next = x_reg;
          OP_SHUP: begin
            link_next = x_reg.man[31:28];
            x_next.man = {x_reg.man[27:0], 4'h0};
          end
          OP_SHDN: begin
            x_next.man = {link_reg, x_reg.man[31:4]};
            link_next = 4'h0;
          end
          OP_ECLR: err_next = 1'b0;
          OP_FULLCLR: begin
            x_next = NUM_ZERO;
            y_next = NUM_ZERO;
            z_next = NUM_ZERO;
            t_next = NUM_ZERO;
            m_next = NUM_ZERO;
            link_next = 4'h0;
            err_next = 1'b0;
            mdc_next = MDC_INIT;
            sci_next = 1'b0;
          end
          OP_BR_COND, OP_BR_XZERO, OP_BR_ERR, OP_BR_ALWAYS: state_next = S_FETCH2;
          default: begin
            if (op_reg >= OP_POWER && op_reg <= OP_DIVIDE) begin
              // Memory form needs the prefix and excludes power
              req_next = 1'b1;
              cmd_next = '{op: {pre_reg, op_reg}, a: x_reg, b: y_reg};
              dst_next = D_XPOP;
              if (pre_reg && op_reg != OP_POWER) begin
                cmd_next.b = m_reg;
                dst_next = D_M;
              end
              state_next = S_MATH;
            end else if (is_unary(op_reg)) begin
              req_next = 1'b1;
              cmd_next = '{op: {pre_reg, op_reg}, a: x_reg, b: y_reg};
              dst_next = D_X;
              state_next = S_MATH;
            end
          end
        endcase
      end
      S_HALT: begin
        // Held long enough that the read-back passes the synchroniser
        if (wait_reg == HALT_DRV_CYC - 11'h1) begin
          wait_next = 11'h0;
          state_next = S_HWAIT;
        end else begin
          wait_next = wait_reg + 11'h1;
        end
      end
      S_HWAIT: if (!hold_s_reg) state_next = S_FETCH;
      default: state_next = S_FETCH;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= S_FETCH;
      x_reg <= NUM_ZERO;  y_reg <= NUM_ZERO;  z_reg <= NUM_ZERO;
      t_reg <= NUM_ZERO;  m_reg <= NUM_ZERO;  dst_reg <= D_X;
      cmd_reg <= '0;  op_reg <= OP_IDLE;  wait_reg <= 11'h0;
      link_reg <= 4'h0;  cnt_reg <= 4'h0;  mdc_reg <= MDC_INIT;
      pca_reg <= 8'h0;  entry_reg <= 1'b0;  exp_reg <= 1'b0;
      enter_reg <= 1'b0;  pre_reg <= 1'b0;  err_reg <= 1'b0;
      sci_reg <= 1'b0;  req_reg <= 1'b0;  pcl_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      x_reg <= x_next;  y_reg <= y_next;  z_reg <= z_next;
      t_reg <= t_next;  m_reg <= m_next;  dst_reg <= dst_next;
      cmd_reg <= cmd_next;  op_reg <= op_next;  wait_reg <= wait_next;
      link_reg <= link_next;  cnt_reg <= cnt_next;  mdc_reg <= mdc_next;
      pca_reg <= pca_next;  entry_reg <= entry_next;  exp_reg <= exp_next;
      enter_reg <= enter_next;  pre_reg <= pre_next;  err_reg <= err_next;
      sci_reg <= sci_next;  req_reg <= req_next;  pcl_reg <= pcl_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdy          = (state_reg == S_FETCH || state_reg == S_FETCH2);
  assign hold_o       = 1'b1;
  assign hold_oe      = (state_reg == S_HALT);
  assign pc_load      = pcl_reg;
  assign pc_target    = pca_reg;
  assign math_req     = req_reg;
  assign math_cmd     = cmd_reg;
  assign x_value      = x_reg;
  assign error_flag   = err_reg;
  assign entry_active = entry_reg;
  assign digit_count  = mdc_reg;
  assign sci_mode     = sci_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic exec_now;
  assign exec_now = (state_reg == S_EXEC);

  a_pi_load: assert property (exec_now && op_reg == OP_PI |=> x_reg == PI_CONST)
    else $error("constant not loaded");
  a_enter_push: assert property (exec_now && op_reg == OP_ENTER |=>
    y_reg == $past(x_reg) && x_reg == $past(x_reg) && t_reg == $past(z_reg) && !entry_reg)
    else $error("enter push wrong");
  a_idle_keeps: assert property (exec_now && op_reg == OP_IDLE |=>
    x_reg == $past(x_reg) && m_reg == $past(m_reg) && !entry_reg)
    else $error("idle op changed state");
  a_halt_drive: assert property (exec_now && op_reg == OP_HALT |=>
    hold_oe [*4] ##1 !hold_oe && !rdy)
    else $error("halt drive wrong");
  a_drop_clear: assert property (exec_now && op_reg == OP_POP |=>
    x_reg == $past(y_reg) && z_reg == $past(t_reg) && t_reg == NUM_ZERO)
    else $error("drop wrong");
  a_mem_swap: assert property (exec_now && op_reg == OP_XSWAPM |=>
    x_reg == $past(m_reg) && m_reg == $past(x_reg))
    else $error("memory swap wrong");
  a_mem_recall: assert property (exec_now && op_reg == OP_MRECALL |=>
    x_reg == $past(m_reg) && y_reg == $past(x_reg))
    else $error("recall wrong");
  a_arith_pop: assert property (state_reg == S_MATH && math_done && dst_reg == D_XPOP |=>
    x_reg == $past(math_result) && y_reg == $past(z_reg) && t_reg == NUM_ZERO)
    else $error("arith pop wrong");
  a_mem_arith: assert property (state_reg == S_MATH && math_done && dst_reg == D_M |=>
    m_reg == $past(math_result) && x_reg == $past(x_reg) && y_reg == $past(y_reg))
    else $error("memory arith wrong");
  a_full_clear: assert property (exec_now && op_reg == OP_FULLCLR |=>
    x_reg == NUM_ZERO && m_reg == NUM_ZERO && mdc_reg == MDC_INIT && !err_reg)
    else $error("full clear wrong");
  a_branch_xzero: assert property (take && state_reg == S_FETCH2 && op_reg == OP_BR_XZERO
    |=> pc_load == ($past(x_reg.man) == 32'h0) && pc_target == $past(instr_word))
    else $error("zero test branch wrong");
  a_math_start: assert property (exec_now && op_reg == OP_ADD |=>
    math_req && math_cmd.a == $past(x_reg) ##1 !math_req)
    else $error("add request wrong");
  a_skip_drop: assert property (take && state_reg == S_FETCH2 |=> !rdy)
    else $error("second word not released");

  c_branch_taken: cover property (state_reg == S_FETCH2 ##1 pc_load);
  c_halt_resume:  cover property (state_reg == S_HWAIT ##1 state_reg == S_FETCH);
  c_normalize:    cover property (state_reg == S_MATH && dst_reg == D_NORM && math_done);

endmodule // rsie_exec

/* tb/rsie_store_model.sv */
// Instruction store with its own program counter, facing the executor.
// Assumes the ready/hold handshake and one-cycle pc_load pulses.
module rsie_store_model
  import rsie_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Executor side
  input  wire logic       rdy,
  input  wire logic       pc_load,
  input  wire logic [7:0] pc_target,
  output logic [7:0]      instr_word,
  // Bench side
  input  wire logic       stall,
  output logic            hold_ext,
  output int              taken,
  output int              loads
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Program
  // ----------------------------------------
  localparam logic [7:0] PROG [42] = '{
    8'h01, 8'h21, 8'h02, 8'h21, 8'h03, 8'h21, 8'h04, 8'h39, 8'hee, 8'h23,
    8'h1c, 8'h0d, 8'h1b, 8'h1d, 8'h39, 8'h20, 8'h39, 8'h37, 8'h14, 8'h15,
    8'h2f, 8'h2b, 8'h14, 8'hee, 8'h0d, 8'h1e, 8'h1f, 8'h24, 8'h10, 8'h1f,
    8'h2f, 8'h10, 8'hee, 8'h2f, 8'h11, 8'h25, 8'h2f, 8'h15, 8'h28, 8'h2f,
    8'h0f, 8'h3f};

  logic [7:0] pc;
  logic [7:0] held;
  logic       rdy_q;

  // ----------------------------------------
  // Fetch side
  // ----------------------------------------
  // Word held while rdy is low, so a late sample still sees it
  assign instr_word = rdy ? ((pc < 8'h2a) ? PROG[pc] : 8'h3f) : held;
  assign hold_ext   = stall;

  always @(negedge clk) begin
    rdy_q <= rdy;
    if (rdy) begin
      held <= instr_word;
    end
    if (reset) begin
      pc    <= 8'h00;
      taken <= 0;
      loads <= 0;
    end else if (pc_load) begin
      pc    <= pc_target;
      loads <= loads + 1;
    end else if (rdy_q && !rdy) begin
      pc    <= pc + 8'h01;
      taken <= taken + 1;
    end
  end
endmodule // rsie_store_model

/* tb/rpn_stack_instruction_executor_bench.sv */
// Self-checking bench: executor, store model and a three-cycle math stand-in.
// Assumes the 2000-cycle fetch wait of the executor; no free parameter.
module rpn_stack_instruction_executor_bench import rsie_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       branch_condition_pin = 1'b0;
  logic       stall = 1'b0;
  logic       math_done = 1'b0;
  logic [1:0] mcnt = 2'h0;
  logic [7:0] instr_word, pc_target;
  logic       rdy, hold_o, hold_oe, hold_ext, pc_load, math_req, math_error;
  logic       error_flag, entry_active, sci_mode;
  logic [3:0] digit_count;
  rsie_mreq_s math_cmd;
  rsie_num_s  math_result, x_value;
  int         taken, loads;
  int         fails = 0;
  int         num_checks = 0;

  always #20 clk = ~clk;

  function automatic rsie_num_s nm(logic [31:0] m);
    return '{ms: 1'b0, man: m, es: 1'b0, ex: 8'h00};
  endfunction
  function automatic rsie_num_s res(logic [6:0] op);
    return nm({25'h0, op});
  endfunction

  // ----------------------------------------
  // Math stand-in
  // ----------------------------------------
  // Normalize echoes X, so entered values stay predictable
  assign math_result = (math_cmd.op == OP_NORMALIZE) ? math_cmd.a : res(math_cmd.op);
  assign math_error  = (math_cmd.op == {1'b0, OP_RECIP});
  always @(negedge clk) begin
    math_done <= (mcnt == 2'h1);
    if (math_req) mcnt <= 2'h3;
    else if (mcnt != 2'h0) mcnt <= mcnt - 2'h1;
  end

  rsie_exec u_rsie_exec (.clk(clk), .reset(reset), .instr_word(instr_word), .rdy(rdy),
    .hold_i((hold_oe & hold_o) | hold_ext), .hold_o(hold_o), .hold_oe(hold_oe),
    .pc_load(pc_load), .pc_target(pc_target), .branch_condition_pin(branch_condition_pin),
    .math_req(math_req), .math_cmd(math_cmd), .math_done(math_done),
    .math_result(math_result), .math_error(math_error), .x_value(x_value),
    .error_flag(error_flag), .entry_active(entry_active), .digit_count(digit_count),
    .sci_mode(sci_mode));
  rsie_store_model u_rsie_store_model (.clk(clk), .reset(reset), .rdy(rdy),
    .pc_load(pc_load), .pc_target(pc_target), .instr_word(instr_word), .stall(stall),
    .hold_ext(hold_ext), .taken(taken), .loads(loads));

  // ----------------------------------------
  // Compare and wait tasks
  // ----------------------------------------
  task automatic chk_num(input string n, input rsie_num_s e, input rsie_num_s a);
    num_checks++;
    if (a !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, a);
    end
  endtask
  task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] a);
    num_checks++;
    if (a !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, a);
    end
  endtask
  task automatic run_to(input int k);
    // Up to six fetches of 2000 cycles may lie between two calls
    for (int i = 0; i < 14000 && !(taken >= k && rdy === 1'b1); i++) @(negedge clk);
    if (!(taken >= k && rdy === 1'b1)) begin
      fails++;
      $display("Error taken expected %0d seen %0d", k, taken);
    end
    repeat (3) @(negedge clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_stack;
    run_to(2);
    chk_num("x_enter", nm(32'h1), x_value);
    chk_val("entry", 32'h0, 32'(entry_active));
    run_to(8);
    chk_num("add_a", nm(32'h4), math_cmd.a);
    chk_num("add_b", nm(32'h3), math_cmd.b);
    chk_num("x_add", res({1'b0, OP_ADD}), x_value);
    run_to(9);
    chk_num("x_pop", nm(32'h2), x_value);
    run_to(10);
    chk_num("x_roll", nm(32'h1), x_value);
  endtask
  task automatic t_memory;
    run_to(11);
    chk_num("x_store", nm(32'h1), x_value);
    run_to(12);
    chk_num("x_const", PI_CONST, x_value);
    run_to(13);
    chk_num("x_swap", nm(32'h1), x_value);
    run_to(14);
    chk_num("x_recall", PI_CONST, x_value);
    run_to(15);
    chk_num("recall_y", nm(32'h1), math_cmd.b);
    run_to(17);
    chk_val("mem_op", 32'({1'b1, OP_ADD}), 32'(math_cmd.op));
    chk_num("mem_b", PI_CONST, math_cmd.b);
    chk_num("x_kept", res({1'b0, OP_ADD}), x_value);
  endtask
  task automatic t_error_branch;
    run_to(18);
    chk_num("x_recip", res({1'b0, OP_RECIP}), x_value);
    chk_val("err_set", 32'h1, 32'(error_flag));
    run_to(20);
    chk_val("loads", 32'h1, 32'(loads));
    chk_val("target", 32'h15, 32'(pc_target));
    run_to(21);
    chk_val("err_clr", 32'h0, 32'(error_flag));
    run_to(23);
    chk_val("loads", 32'h1, 32'(loads));
  endtask
  task automatic t_shift;
    run_to(24);
    chk_num("x_up", nm(32'h14159270), x_value);
    run_to(25);
    chk_num("x_down", PI_CONST, x_value);
    run_to(26);
    chk_num("x_trig", res({1'b0, OP_SIN}), x_value);
  endtask
  task automatic t_branches;
    branch_condition_pin = 1'b1;
    run_to(28);
    chk_val("loads", 32'h2, 32'(loads));
    chk_val("target", 32'h1f, 32'(pc_target));
    // Pin low before the second test's target word is taken
    branch_condition_pin = 1'b0;
    run_to(31);
    chk_val("loads", 32'h2, 32'(loads));
    run_to(32);
    chk_num("x_clear", NUM_ZERO, x_value);
    chk_val("digits", 32'(MDC_INIT), 32'(digit_count));
    chk_val("sci", 32'h0, 32'(sci_mode));
    chk_val("loads", 32'h3, 32'(loads));
    chk_val("target", 32'h25, 32'(pc_target));
  endtask
  task automatic t_halt;
    for (int i = 0; i < 6000 && hold_oe !== 1'b1; i++) @(negedge clk);
    stall = 1'b1;
    chk_val("hold_oe", 32'h1, 32'(hold_oe));
    chk_val("loads", 32'h4, 32'(loads));
    chk_val("target", 32'h28, 32'(pc_target));
    repeat (60) @(negedge clk);
    chk_val("rdy_held", 32'h0, 32'(rdy));
    stall = 1'b0;
    run_to(34);
    chk_val("taken", 32'd34, 32'(taken));
  endtask

  task automatic end_of_test;
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge clk);
    reset = 1'b0;
    t_stack;
    t_memory;
    t_error_branch;
    t_shift;
    t_branches;
    t_halt;
    end_of_test;
  end

  // Run needs about 76200 cycles; stop well past that
  initial begin
    repeat (85000) @(posedge clk);
    fails++;
    end_of_test;
  end
endmodule // rpn_stack_instruction_executor_bench
